// File: hw/wwdt_pkg.sv
package wwdt_pkg;
    localparam int          APB_AW       = 8;
    localparam int          CNT_TOTAL_W  = 23;
    localparam int          RATIO_W      = 24;
    // register byte addresses
    localparam logic [7:0]  OFF_CTRL0    = 8'h00;
    localparam logic [7:0]  OFF_CTRL1    = 8'h04;
    localparam logic [7:0]  OFF_DEBUG    = 8'h08;
    localparam logic [7:0]  OFF_PWRCTL   = 8'h0C;
    // field positions
    localparam int          C0_SEN_BIT   = 0;
    localparam int          C0_PS_LSB    = 1;
    localparam int          C1_WIN_LSB   = 0;
    localparam int          C1_CS_LSB    = 4;
    localparam int          DBG_CNT_LSB  = 18;
    localparam int          DBG_ARM_BIT  = 23;
    localparam int          PC_WV_BIT    = 0;
    localparam int          PC_TIMEOUT_RESET_FLAG_N_BIT  = 1;
    localparam int          PC_TO_BIT    = 2;
    localparam int          PC_PD_BIT    = 3;
    // codes and reset values
    localparam logic [1:0]  MODE_OFF     = 2'h0;
    localparam logic [1:0]  MODE_SOFT    = 2'h1;
    localparam logic [1:0]  MODE_AWAKE   = 2'h2;
    localparam logic [1:0]  MODE_ON      = 2'h3;
    localparam logic [2:0]  CS_LF        = 3'h0;
    localparam logic [2:0]  CS_MF        = 3'h1;
    localparam logic [2:0]  CS_SOFT      = 3'h7;
    localparam logic [4:0]  PS_SOFT      = 5'h1F;
    localparam logic [4:0]  PS_DEFAULT   = 5'h0B;
    localparam logic [4:0]  PS_MAX       = 5'h12;
    localparam logic [2:0]  WIN_FULL     = 3'h7;
    localparam logic [23:0] RATIO_MIN    = 24'h000020;

    function automatic logic [23:0] ratio_of(input logic [4:0] ps);
        ratio_of = (ps > PS_MAX) ? RATIO_MIN : RATIO_MIN << ps;
    endfunction

    function automatic logic window_closed(input logic [22:0] cnt,
                                           input logic [4:0]  ps,
                                           input logic [2:0]  win);
        logic [26:0] delay;
        delay = 27'(WIN_FULL - win) * 27'(ratio_of(ps) >> 3);
        window_closed = (win != WIN_FULL) && ({4'h0, cnt} < delay);
    endfunction
endpackage

// File: hw/wwdt_cnt_if.sv
interface wwdt_cnt_if;
    logic        tick;
    logic        clear;
    logic [4:0]  ps_sel;
    logic [22:0] count;
    logic        timeout;
    modport ctl (output tick, clear, ps_sel, input count, timeout);
    modport cnt (input tick, clear, ps_sel, output count, timeout);
endinterface

// File: hw/wwdt_counter.sv
module wwdt_counter
    import wwdt_pkg::*;
#(
    parameter int PRESCALE_W = 18,
    parameter int COUNT_W    = 5
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control side
    wwdt_cnt_if.cnt  cif
);
    if (PRESCALE_W + COUNT_W != CNT_TOTAL_W) begin : g_chk
        $error("prescaler plus counter must be 23 bits");
    end

    logic [22:0] count_q;
    logic        timeout_q;
    logic        at_end;

    assign at_end = cif.tick &&
                    ({1'b0, count_q} == ratio_of(cif.ps_sel) - 24'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q   <= '0;
            timeout_q <= 1'b0;
        end else if (cif.clear) begin
            count_q   <= '0;
            timeout_q <= 1'b0;
        end else if (at_end) begin
            count_q   <= '0;
            timeout_q <= 1'b1;
        end else begin
            count_q   <= cif.tick ? 23'(count_q + 23'h1) : count_q;
            timeout_q <= 1'b0;
        end
    end

    assign cif.count   = count_q;
    assign cif.timeout = timeout_q;

    a_ratio_min: assert property (
        @(posedge pclk) disable iff (!presetn)
        cif.tick && !cif.clear && cif.ps_sel > PS_MAX &&
        count_q == 23'h1F |=> timeout_q && count_q == '0)
        else $error("reserved prescale code did not time out at 32");
endmodule // wwdt_counter

// File: hw/wwdt_top.sv
module wwdt_top
    import wwdt_pkg::*;
#(
    parameter int PRESCALE_W = 18,
    parameter int COUNT_W    = 5
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // configuration words
    input  wire logic [1:0]        cfg_enable_mode,
    input  wire logic [4:0]        cfg_prescale_select,
    input  wire logic [2:0]        cfg_clock_select,
    input  wire logic [2:0]        cfg_window_select,
    // processor core and clock logic
    input  wire logic              kick_instruction,
    input  wire logic              sleep_mode,
    input  wire logic              oscillator_startup_timer,
    input  wire logic              osc_fail,
    input  wire logic              low_freq_internal_osc,
    input  wire logic              mid_freq_internal_osc,
    // reset and status logic
    output logic                   wdt_reset_req,
    output logic                   wake_req,
    output logic                   window_violation_n,
    output logic                   timeout_reset_flag_n,
    output logic                   expiry_indicator_flag_n,
    output logic                   power_down_flag_n
);
    wwdt_cnt_if cif ();

    wwdt_counter #(
        .PRESCALE_W (PRESCALE_W),
        .COUNT_W    (COUNT_W)
    ) u_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif)
    );

    // oscillator pins cross into pclk
    logic       lf_s1_q;
    logic       lf_s2_q;
    logic       lf_s3_q;
    logic       mf_s1_q;
    logic       mf_s2_q;
    logic       mf_s3_q;
    logic       lf_edge;
    logic       mf_edge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_s1_q <= 1'b0;
            lf_s2_q <= 1'b0;
            lf_s3_q <= 1'b0;
            mf_s1_q <= 1'b0;
            mf_s2_q <= 1'b0;
            mf_s3_q <= 1'b0;
        end else begin
            lf_s1_q <= low_freq_internal_osc;
            lf_s2_q <= lf_s1_q;
            lf_s3_q <= lf_s2_q;
            mf_s1_q <= mid_freq_internal_osc;
            mf_s2_q <= mf_s1_q;
            mf_s3_q <= mf_s2_q;
        end
    end

    assign lf_edge = lf_s2_q & ~lf_s3_q;
    assign mf_edge = mf_s2_q & ~mf_s3_q;

    // configuration captured one edge after reset release
    logic       init_q;
    logic [1:0] cfg_mode_q;
    logic [4:0] cfg_ps_q;
    logic [2:0] cfg_cs_q;
    logic [2:0] cfg_win_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q     <= 1'b0;
            cfg_mode_q <= MODE_OFF;
            cfg_ps_q   <= PS_DEFAULT;
            cfg_cs_q   <= CS_LF;
            cfg_win_q  <= WIN_FULL;
        end else if (!init_q) begin
            init_q     <= 1'b1;
            cfg_mode_q <= cfg_enable_mode;
            cfg_ps_q   <= cfg_prescale_select;
            cfg_cs_q   <= cfg_clock_select;
            cfg_win_q  <= cfg_window_select;
        end
    end

    // apb decode
    logic       setup;
    logic       access;
    logic       wr_done;
    logic       rd_done;
    logic       hit_c0;
    logic       hit_c1;
    logic       hit_dbg;
    logic       hit_pc;
    logic       mapped;
    logic       ctrl_wr;
    logic       pc_wr;
    logic       arm_rd;
    logic       pready_q;
    logic       pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;

    assign setup   = psel & ~penable;
    assign access  = psel & penable & pready_q;
    assign wr_done = access & pwrite;
    assign rd_done = access & ~pwrite;
    assign hit_c0  = paddr == OFF_CTRL0;
    assign hit_c1  = paddr == OFF_CTRL1;
    assign hit_dbg = paddr == OFF_DEBUG;
    assign hit_pc  = paddr == OFF_PWRCTL;
    assign mapped  = hit_c0 | hit_c1 | hit_dbg | hit_pc;
    assign ctrl_wr = wr_done & (hit_c0 | hit_c1);
    assign pc_wr   = wr_done & hit_pc;
    assign arm_rd  = rd_done & hit_c0;

    // control fields
    logic       sen_q;
    logic [4:0] ps_q;
    logic [2:0] cs_q;
    logic [2:0] win_q;
    logic       ps_wr_ok;
    logic       cs_wr_ok;
    logic       win_wr_ok;

    assign ps_wr_ok  = cfg_ps_q == PS_SOFT;
    assign cs_wr_ok  = cfg_cs_q == CS_SOFT;
    assign win_wr_ok = cfg_win_q == WIN_FULL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sen_q <= 1'b0;
            ps_q  <= PS_DEFAULT;
            cs_q  <= CS_LF;
            win_q <= WIN_FULL;
        end else if (!init_q) begin
            sen_q <= 1'b0;
            ps_q  <= (cfg_prescale_select == PS_SOFT) ?
                     PS_DEFAULT : cfg_prescale_select;
            cs_q  <= (cfg_clock_select == CS_SOFT) ? CS_LF
                                                   : cfg_clock_select;
            win_q <= cfg_window_select;
        end else begin
            if (wr_done & hit_c0) begin
                sen_q <= pwdata[C0_SEN_BIT];
                if (ps_wr_ok) begin
                    ps_q <= pwdata[C0_PS_LSB +: 5];
                end
            end
            if (wr_done & hit_c1) begin
                if (cs_wr_ok) begin
                    cs_q <= pwdata[C1_CS_LSB +: 3];
                end
                if (win_wr_ok) begin
                    win_q <= pwdata[C1_WIN_LSB +: 3];
                end
            end
        end
    end

    // enable, window and kick judgement
    logic       sleep_q;
    logic       sleep_enter;
    logic       sleep_exit;
    logic       en;
    logic       windowed;
    logic       closed;
    logic       kick_en;
    logic       kick_bad;
    logic       kick_ok;
    logic       armed_q;
    logic       to_awake;
    logic       to_sleep;

    assign en = init_q &
                ((cfg_mode_q == MODE_ON) |
                 ((cfg_mode_q == MODE_AWAKE) & ~sleep_mode) |
                 ((cfg_mode_q == MODE_SOFT) & sen_q));
    assign sleep_enter = sleep_mode & ~sleep_q;
    assign sleep_exit  = ~sleep_mode & sleep_q;
    assign windowed    = win_q != WIN_FULL;
    assign closed      = window_closed(cif.count, ps_q, win_q);
    assign kick_en     = kick_instruction & en;
    assign kick_bad    = kick_en & windowed &
                         (closed | ~armed_q);
    assign kick_ok     = kick_en & ~kick_bad;
    assign to_awake    = cif.timeout & ~sleep_mode;
    assign to_sleep    = cif.timeout & sleep_mode;

    // reserved clock codes stop the time base
    assign cif.tick   = (cs_q == CS_LF) ? lf_edge :
                        (cs_q == CS_MF) ? mf_edge : 1'b0;
    assign cif.ps_sel = ps_q;
    // divider changes arrive as control writes, so ctrl_wr clears the count
    assign cif.clear  = ~en | kick_ok | sleep_enter | sleep_exit |
                        oscillator_startup_timer | osc_fail |
                        ctrl_wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            sleep_q <= sleep_mode;
            // arming read wins over a same-cycle kick
            armed_q <= arm_rd ? 1'b1 :
                       (kick_en ? 1'b0 : armed_q);
        end
    end

    // requests and status flags
    logic       rst_q;
    logic       wake_q;
    logic       wv_n_q;
    logic       timeout_reset_flag_n_n_q;
    logic       to_n_q;
    logic       pd_n_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            rst_q  <= to_awake | kick_bad;
            wake_q <= to_sleep;
        end
    end

    // hardware events beat a same-cycle firmware write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wv_n_q   <= 1'b1;
            timeout_reset_flag_n_n_q <= 1'b1;
            to_n_q   <= 1'b1;
            pd_n_q   <= 1'b1;
        end else begin
            wv_n_q   <= kick_bad ? 1'b0 :
                        pc_wr ? pwdata[PC_WV_BIT] : wv_n_q;
            timeout_reset_flag_n_n_q <= to_awake ? 1'b0 :
                        pc_wr ? pwdata[PC_TIMEOUT_RESET_FLAG_N_BIT] : timeout_reset_flag_n_n_q;
            to_n_q   <= cif.timeout ? 1'b0 :
                        (kick_ok | sleep_enter) ? 1'b1 :
                        pc_wr ? pwdata[PC_TO_BIT] : to_n_q;
            pd_n_q   <= (sleep_enter | to_sleep) ? 1'b0 :
                        kick_ok ? 1'b1 :
                        pc_wr ? pwdata[PC_PD_BIT] : pd_n_q;
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        rd_mux = '0;
        if (hit_c0) begin
            rd_mux[C0_SEN_BIT]     = sen_q;
            rd_mux[C0_PS_LSB +: 5] = ps_q;
        end
        if (hit_c1) begin
            rd_mux[C1_CS_LSB +: 3]  = cs_q;
            rd_mux[C1_WIN_LSB +: 3] = win_q;
        end
        if (hit_dbg) begin
            rd_mux[DBG_ARM_BIT:0] = {armed_q, cif.count};
        end
        if (hit_pc) begin
            rd_mux[PC_WV_BIT]   = wv_n_q;
            rd_mux[PC_TIMEOUT_RESET_FLAG_N_BIT] = timeout_reset_flag_n_n_q;
            rd_mux[PC_TO_BIT]   = to_n_q;
            rd_mux[PC_PD_BIT]   = pd_n_q;
        end
    end

    // one access cycle: ready follows the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q  <= (setup & ~pwrite) ? rd_mux : '0;
        end
    end

    assign prdata                  = prdata_q;
    assign pready                  = pready_q;
    assign pslverr                 = pslverr_q;
    assign wdt_reset_req           = rst_q;
    assign wake_req                = wake_q;
    assign window_violation_n      = wv_n_q;
    assign timeout_reset_flag_n    = timeout_reset_flag_n_n_q;
    assign expiry_indicator_flag_n = to_n_q;
    assign power_down_flag_n       = pd_n_q;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_bad_kick;
        kick_instruction && en && windowed;
    endsequence

    sequence s_reset_only;
        rst_q && !wake_q;
    endsequence

    a_mode_off: assert property (
        init_q && cfg_mode_q == MODE_OFF |=> cif.count == '0 && !rst_q)
        else $error("mode off let the count run");
    a_sleep_off: assert property (
        init_q && cfg_mode_q == MODE_AWAKE && sleep_mode |=> cif.count == '0)
        else $error("awake-only mode counted in sleep");
    a_soft_off: assert property (
        init_q && cfg_mode_q == MODE_SOFT && !sen_q |=> cif.count == '0)
        else $error("soft mode counted with enable low");
    a_sleep_wake: assert property (
        cfg_mode_q == MODE_ON && sleep_mode && cif.timeout
        |=> wake_q && !rst_q && !to_n_q && !pd_n_q)
        else $error("sleep timeout did not wake");
    a_kick_closed: assert property (
        s_bad_kick ##0 closed |=> s_reset_only ##0 !wv_n_q)
        else $error("closed-window kick did not reset");
    a_kick_unarmed: assert property (
        s_bad_kick ##0 !armed_q |=> s_reset_only)
        else $error("unarmed kick did not reset");
    a_awake_to: assert property (
        cif.timeout && !sleep_mode |=> s_reset_only ##0 !timeout_reset_flag_n_n_q)
        else $error("awake timeout did not reset");
    a_ctrl_clear: assert property (
        ctrl_wr |=> cif.count == '0)
        else $error("control write left count");
    a_ost_hold: assert property (
        oscillator_startup_timer [*2] |-> cif.count == '0)
        else $error("count moved during startup timer");
    a_ro_clock: assert property (
        wr_done && hit_c1 && !cs_wr_ok |=> $stable(cs_q))
        else $error("read-only clock select changed");
    a_ro_prescale: assert property (
        wr_done && hit_c0 && !ps_wr_ok |=> $stable(ps_q))
        else $error("read-only prescale changed");
    a_disarm: assert property (
        kick_en && !arm_rd |=> !armed_q)
        else $error("kick left watchdog armed");
endmodule // wwdt_top

// File: bench/wwdt_osc_model.sv
module wwdt_osc_model (
    // clock and run gate
    input  wire logic pclk,
    input  wire logic run,
    // oscillator pins and rising edge counts
    output logic      lf_osc,
    output logic      mf_osc,
    output int        lf_n,
    output int        mf_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int ph;
    // oscillators stand still between runs so the count phase is known
    always @(posedge pclk) begin
        if (!run) begin
            ph <= 0;
            lf_osc <= 1'b0;
            mf_osc <= 1'b0;
            lf_n <= 0;
            mf_n <= 0;
        end else begin
            ph <= ph + 1;
            if (ph % 8 == 7) begin // low oscillator, 16 pclk period
                lf_osc <= ~lf_osc;
                lf_n <= lf_n + int'(!lf_osc);
            end
            if (ph % 6 == 5) begin // mid oscillator, 12 pclk period
                mf_osc <= ~mf_osc;
                mf_n <= mf_n + int'(!mf_osc);
            end
        end
    end
endmodule // wwdt_osc_model

// File: bench/test_wwdt_top.sv
module test_wwdt_top;
    import wwdt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  cfg_enable_mode;
    logic [4:0]  cfg_prescale_select;
    logic [2:0]  cfg_clock_select, cfg_window_select;
    logic        kick_instruction, sleep_mode, oscillator_startup_timer;
    logic        osc_fail, low_freq_internal_osc, mid_freq_internal_osc;
    logic        wdt_reset_req, wake_req, window_violation_n, err, run;
    logic        timeout_reset_flag_n, expiry_indicator_flag_n;
    logic        power_down_flag_n;
    logic [4:0]  pst[4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
    logic [31:0] rat[4] = '{32'h20, 32'h40, 32'h20, 32'h20};
    int          miscompares, compares, nrst, nwake, r0, w0, fe, cyc, lf_n;
    int          mf_n;

    wwdt_top wwdt_top_inst (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .cfg_enable_mode, .cfg_prescale_select,
        .cfg_clock_select, .cfg_window_select, .kick_instruction,
        .sleep_mode, .oscillator_startup_timer, .osc_fail,
        .low_freq_internal_osc, .mid_freq_internal_osc, .wdt_reset_req,
        .wake_req, .window_violation_n, .timeout_reset_flag_n,
        .expiry_indicator_flag_n, .power_down_flag_n
    );
    wwdt_osc_model wwdt_osc_model_inst (
        .pclk, .run, .lf_osc(low_freq_internal_osc),
        .mf_osc(mid_freq_internal_osc), .lf_n, .mf_n
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (wdt_reset_req === 1'b1) nrst++;
        if (wake_req === 1'b1) nwake++;
        if (cyc == 60000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic boot(input logic [1:0] m, input logic [4:0] p,
                        input logic [2:0] c, input logic [2:0] w);
        @(posedge pclk);
        presetn <= 1'b0;
        cfg_enable_mode <= m;
        cfg_prescale_select <= p;
        cfg_clock_select <= c;
        cfg_window_select <= w;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // run the oscillators until a reset or wake pulse or lim edges
    task automatic watch(input int lim, input logic m);
        r0 = nrst;
        w0 = nwake;
        fe = 0;
        @(posedge pclk);
        run <= 1'b1;
        while (nrst == r0 && nwake == w0 && fe < lim) begin
            @(posedge pclk);
            fe = m ? mf_n : lf_n;
        end
        run <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic kick_chk(input logic [31:0] exp);
        r0 = nrst;
        @(posedge pclk);
        kick_instruction <= 1'b1;
        @(posedge pclk);
        kick_instruction <= 1'b0;
        repeat (4) @(posedge pclk);
        check(32'(nrst - r0), exp);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, kick_instruction, run} = '0;
        {sleep_mode, oscillator_startup_timer, osc_fail} = '0;
        {paddr, pwdata} = '0;
        {cfg_enable_mode, cfg_prescale_select} = '0;
        {cfg_clock_select, cfg_window_select} = '0;
        boot(MODE_ON, PS_SOFT, CS_SOFT, WIN_FULL);
        apb(1'b0, OFF_CTRL0, 32'h0);
        check(rd, {26'h0, PS_DEFAULT, 1'b0});
        apb(1'b0, OFF_CTRL1, 32'h0);
        check(rd, 32'h07);
        apb(1'b0, OFF_PWRCTL, 32'h0);
        check(rd, 32'h0F);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_CTRL0, {26'h0, pst[i], 1'b0});
            watch(200, 1'b0);
            check(32'(fe), rat[i]);
            check(32'(nrst - r0), 32'h1);
        end
        check({30'h0, timeout_reset_flag_n, expiry_indicator_flag_n},
              32'h0);
        apb(1'b1, OFF_CTRL1, 32'h17);
        apb(1'b0, OFF_CTRL1, 32'h0);
        check(rd, 32'h17);
        watch(200, 1'b1);
        check(32'(fe), 32'h20);
        oscillator_startup_timer <= 1'b1;
        apb(1'b1, OFF_CTRL1, 32'h07);
        watch(40, 1'b0);
        check(32'(nrst - r0), 32'h0);
        apb(1'b0, OFF_DEBUG, 32'h0);
        check({8'h0, rd[23:0]}, 32'h0080_0000);
        oscillator_startup_timer <= 1'b0;
        watch(20, 1'b0);
        osc_fail <= 1'b1;
        @(posedge pclk);
        osc_fail <= 1'b0;
        watch(200, 1'b0);
        check(32'(fe), 32'h20);
        sleep_mode <= 1'b1;
        watch(200, 1'b0);
        check(32'(fe), 32'h20);
        check(32'(nwake - w0), 32'h1);
        check(32'(nrst - r0), 32'h0);
        check({31'h0, power_down_flag_n}, 32'h0);
        sleep_mode <= 1'b0;
        boot(MODE_SOFT, 5'h00, CS_LF, 3'h3);
        apb(1'b1, OFF_CTRL0, 32'h0A);
        apb(1'b0, OFF_CTRL0, 32'h0);
        check(rd, 32'h0);
        watch(40, 1'b0);
        check(32'(nrst - r0), 32'h0);
        apb(1'b1, OFF_CTRL1, 32'h77);
        apb(1'b0, OFF_CTRL1, 32'h0);
        check(rd, 32'h03);
        apb(1'b1, OFF_CTRL0, 32'h01);
        apb(1'b0, OFF_CTRL0, 32'h0);
        kick_chk(32'h1);
        check({31'h0, window_violation_n}, 32'h0);
        apb(1'b1, OFF_PWRCTL, 32'h0F);
        @(posedge pclk);
        check({31'h0, window_violation_n}, 32'h1);
        apb(1'b1, OFF_CTRL0, 32'h01);
        watch(20, 1'b0);
        kick_chk(32'h1);
        apb(1'b1, OFF_CTRL0, 32'h01);
        watch(20, 1'b0);
        apb(1'b0, OFF_CTRL0, 32'h0); // arming read
        apb(1'b0, OFF_DEBUG, 32'h0);
        check({31'h0, rd[DBG_ARM_BIT]}, 32'h1);
        kick_chk(32'h0);
        apb(1'b0, OFF_DEBUG, 32'h0);
        check({8'h0, rd[23:0]}, 32'h0);
        boot(MODE_OFF, 5'h00, CS_LF, WIN_FULL);
        apb(1'b1, OFF_CTRL0, 32'h01);
        watch(40, 1'b0);
        check(32'(nrst - r0), 32'h0);
        boot(MODE_AWAKE, 5'h00, CS_LF, WIN_FULL);
        sleep_mode <= 1'b1;
        watch(40, 1'b0);
        check(32'(nrst - r0 + nwake - w0), 32'h0);
        sleep_mode <= 1'b0;
        apb(1'b1, OFF_CTRL0, 32'h0);
        watch(200, 1'b0);
        check(32'(fe), 32'h20);
        complete_run();
    end
endmodule // test_wwdt_top
